/* logic/ebr_pkg.sv */
/*
  Package for the external bus ready and hold arbiter: register map, field positions,
  reset values, clock output timing and the state encoding shared by the design.
  Assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
`default_nettype none
package ebr_pkg;
  // system clock and exported clock output
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned CLOCK_OUTPUT_PIN_PERIOD_NS = 20;
  localparam int unsigned CLOCK_OUTPUT_PIN_HALF_CYCLES = (CLOCK_OUTPUT_PIN_PERIOD_NS / 2 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // register byte offsets
  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] CMD_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // configuration fields
  localparam int unsigned CFG_WAIT_LSB = 0;
  localparam int unsigned CFG_WAIT_W = 4;
  localparam int unsigned CFG_RWDLY_BIT = 4;
  localparam int unsigned CFG_MUX_BIT = 5;
  localparam int unsigned CFG_TRI_BIT = 6;
  localparam int unsigned CFG_RDY_EN_BIT = 7;
  localparam int unsigned CFG_WANT_BIT = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0080;

  // command fields
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_WRITE_BIT = 1;

  // status fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_PEND_BIT = 4;
  localparam int unsigned STAT_GRANT_BIT = 5;
  localparam int unsigned STAT_REL_BIT = 6;
  localparam int unsigned STAT_RWAIT_LSB = 16;

  typedef enum logic [3:0] {
    EBR_IDLE = 4'h0,
    EBR_ADDR = 4'h1,
    EBR_DLY = 4'h3,
    EBR_ACC = 4'h2,
    EBR_MUXW = 4'h6,
    EBR_TRIW = 4'h7,
    EBR_REL = 4'h5,
    EBR_HELD = 4'h4,
    EBR_REGN = 4'hc
  } ebr_state_e;

  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic cs_oe;
    logic bus_oe;
    logic grant_n;
    logic bus_request_out_n;
  } ebr_pins_s;
endpackage : ebr_pkg
`default_nettype wire

/* logic/ebr_arbiter.sv */
/*
  External bus cycle controller: ready-controlled waitstates, cycle end with post-cycle
  idle and tristate waitstates, and hold / grant / bus-request arbitration.
  Assumes an APB master on CLOCK, external pullups on the chip selects and on the
  ready and hold lines, and pins resolved from the enables by the surroundings.
*/
// Added by the designer: the placing of the registers and the APB interface to the registers.
`default_nettype none
module ebr_arbiter
  import ebr_pkg::*;
#(
  parameter int unsigned CLOCK_OUTPUT_PIN_HALF = CLOCK_OUTPUT_PIN_HALF_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic READY_N,
  input wire logic HOLD_N,
  output logic CLOCK_OUTPUT_PIN,
  output logic ALE,
  output logic RD_N,
  output logic WR_N,
  output logic BUS_OE,
  output logic CS_N,
  output logic CS_N_OE,
  output logic HOLD_GRANT_N,
  output logic BUS_REQUEST_OUT_N
);

  typedef struct packed {
    ebr_state_e st;
    logic [2:0] rdy_sync;
    logic [2:0] hld_sync;
    logic rdy_f;
    logic hld_f;
    logic [7:0] div;
    logic clk;
    logic [CFG_WAIT_W-1:0] wcnt;
    logic [8:0] cfg;
    logic pend;
    logic pend_wr;
    logic cyc_wr;
    logic [15:0] rdy_waits;
    logic [31:0] prdata;
    logic pslverr;
    ebr_pins_s pins;
  } ebr_regs_s;

  ebr_regs_s r_ff;
  ebr_regs_s nxt_r;
  logic tick;
  logic setup;
  logic acc_wr;
  logic at_sample;
  logic rdy_wait;

  ////////////////////////////////////////////////////////////////////////////
  // decoding used by the next-state logic and by the APB register interface

  function automatic ebr_pins_s pins_of(input ebr_state_e s, input logic wr, input logic req);
    ebr_pins_s p;
    p.ale = (s == EBR_ADDR);
    p.rd_n = !((s == EBR_ACC) && !wr);
    p.wr_n = !((s == EBR_ACC) && wr);
    p.cs_n = !((s == EBR_ADDR) || (s == EBR_DLY) || (s == EBR_ACC));
    p.cs_oe = !((s == EBR_REL) || (s == EBR_HELD) || (s == EBR_REGN));
    p.bus_oe = p.cs_oe;
    p.grant_n = (s != EBR_HELD);
    p.bus_request_out_n = !((s == EBR_HELD) && req);
    return p;
  endfunction

  function automatic logic is_offset(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock output and bus cycle sequencing

  // one cycle before the clock output rises
  assign tick = (r_ff.div == 8'(CLOCK_OUTPUT_PIN_HALF - 1)) && !r_ff.clk;
  assign setup = PSEL && !PENABLE;
  assign acc_wr = PSEL && PENABLE && PWRITE;
  assign at_sample = (r_ff.st == EBR_ACC) && (r_ff.wcnt == '0);
  assign rdy_wait = r_ff.cfg[CFG_RDY_EN_BIT] && r_ff.rdy_f;

  always_comb begin
    nxt_r = r_ff;
    // three-stage synchronisers; value taken only when the last two agree
    nxt_r.rdy_sync = {r_ff.rdy_sync[1:0], READY_N};
    nxt_r.hld_sync = {r_ff.hld_sync[1:0], HOLD_N};
    if (r_ff.rdy_sync[1] == r_ff.rdy_sync[2]) begin
      nxt_r.rdy_f = r_ff.rdy_sync[2];
    end
    if (r_ff.hld_sync[1] == r_ff.hld_sync[2]) begin
      nxt_r.hld_f = r_ff.hld_sync[2];
    end
    if (r_ff.div == 8'(CLOCK_OUTPUT_PIN_HALF - 1)) begin
      nxt_r.div = '0;
      nxt_r.clk = !r_ff.clk;
    end else begin
      nxt_r.div = r_ff.div + 8'h01;
    end

    if (tick) begin
      unique case (r_ff.st)
        EBR_IDLE: begin
          // only reached between cycles, so a running cycle is never cut short
          if (!r_ff.hld_f) begin
            nxt_r.st = EBR_REL;
          end
        end
        EBR_ADDR: begin
          nxt_r.st = r_ff.cfg[CFG_RWDLY_BIT] ? EBR_DLY : EBR_ACC;
        end
        EBR_DLY: begin
          nxt_r.st = EBR_ACC;
        end
        EBR_ACC: begin
          if (r_ff.wcnt != '0) begin
            nxt_r.wcnt = r_ff.wcnt - 1'b1;
          end else if (rdy_wait) begin
            nxt_r.rdy_waits = r_ff.rdy_waits + 16'h0001;
          end else if (r_ff.cfg[CFG_MUX_BIT]) begin
            nxt_r.st = EBR_MUXW;
          end else if (r_ff.cfg[CFG_TRI_BIT]) begin
            nxt_r.st = EBR_TRIW;
          end else begin
            nxt_r.st = EBR_IDLE;
          end
        end
        EBR_MUXW: begin
          nxt_r.st = r_ff.cfg[CFG_TRI_BIT] ? EBR_TRIW : EBR_IDLE;
        end
        EBR_TRIW: begin
          nxt_r.st = EBR_IDLE;
        end
        EBR_REL: begin
          nxt_r.st = EBR_HELD;
        end
        EBR_HELD: begin
          // an early bus request does not shorten the hold; only hold going high does
          if (r_ff.hld_f) begin
            nxt_r.st = EBR_REGN;
          end
        end
        EBR_REGN: begin
          nxt_r.st = EBR_IDLE;
        end
        default: begin
          nxt_r.st = EBR_IDLE;
        end
      endcase
      // a waiting start follows the end of a cycle at once, so no idle clock output
      // is added to the gap; a bus just regained still idles one clock output first
      // hold wins: with hold active the idle step leads on to release instead
      if ((nxt_r.st == EBR_IDLE) && (r_ff.st != EBR_REGN) && r_ff.hld_f && r_ff.pend) begin
        nxt_r.st = EBR_ADDR;
        nxt_r.pend = 1'b0;
        nxt_r.cyc_wr = r_ff.pend_wr;
        nxt_r.wcnt = r_ff.cfg[CFG_WAIT_LSB +: CFG_WAIT_W];
      end
      nxt_r.pins = pins_of(nxt_r.st, nxt_r.cyc_wr, r_ff.cfg[CFG_WANT_BIT] && nxt_r.pend);
    end

    // apb slave: read data captured in setup, so the access phase always ends at once
    if (setup) begin
      nxt_r.pslverr = 1'b0;
      nxt_r.prdata = 32'h0000_0000;
      if (is_offset(PADDR, CFG_OFFSET)) begin
        nxt_r.prdata = {23'h00_0000, r_ff.cfg};
      end else if (is_offset(PADDR, STATUS_OFFSET)) begin
        nxt_r.prdata[STAT_STATE_LSB +: 4] = r_ff.st;
        nxt_r.prdata[STAT_PEND_BIT] = r_ff.pend;
        nxt_r.prdata[STAT_GRANT_BIT] = !r_ff.pins.grant_n;
        nxt_r.prdata[STAT_REL_BIT] = !r_ff.pins.bus_oe;
        nxt_r.prdata[STAT_RWAIT_LSB +: 16] = r_ff.rdy_waits;
      end else if (!is_offset(PADDR, CMD_OFFSET)) begin
        nxt_r.pslverr = 1'b1;
      end
    end
    if (acc_wr && is_offset(PADDR, CFG_OFFSET)) begin
      nxt_r.cfg = PWDATA[8:0];
    end
    // a new start beats the clear done by a cycle that begins in the same edge
    if (acc_wr && is_offset(PADDR, CMD_OFFSET) && PWDATA[CMD_START_BIT]) begin
      nxt_r.pend = 1'b1;
      nxt_r.pend_wr = PWDATA[CMD_WRITE_BIT];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      r_ff <= '{
        st: EBR_IDLE,
        rdy_sync: 3'h7,
        hld_sync: 3'h7,
        rdy_f: 1'b1,
        hld_f: 1'b1,
        div: 8'h00,
        clk: 1'b0,
        wcnt: '0,
        cfg: CFG_RESET[8:0],
        pend: 1'b0,
        pend_wr: 1'b0,
        cyc_wr: 1'b0,
        rdy_waits: 16'h0000,
        prdata: 32'h0000_0000,
        pslverr: 1'b0,
        pins: '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, cs_oe: 1'b1, bus_oe: 1'b1,
                grant_n: 1'b1, bus_request_out_n: 1'b1}
      };
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign PRDATA = r_ff.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = r_ff.pslverr;
  assign CLOCK_OUTPUT_PIN = r_ff.clk;
  assign ALE = r_ff.pins.ale;
  assign RD_N = r_ff.pins.rd_n;
  assign WR_N = r_ff.pins.wr_n;
  assign BUS_OE = r_ff.pins.bus_oe;
  assign CS_N = r_ff.pins.cs_n;
  assign CS_N_OE = r_ff.pins.cs_oe;
  assign HOLD_GRANT_N = r_ff.pins.grant_n;
  assign BUS_REQUEST_OUT_N = r_ff.pins.bus_request_out_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_sample_point;
    tick && at_sample;
  endsequence

  sequence s_cycle_end;
    s_sample_point ##0 !rdy_wait;
  endsequence

  sequence s_strobes_off;
    RD_N && WR_N;
  endsequence

  AST_READY_HIGH_WAITS: assert property (
    s_sample_point ##0 rdy_wait |=> (r_ff.st == EBR_ACC) && (RD_N != WR_N)
  ) else $error("ready high did not add a waitstate");

  AST_READY_LOW_ENDS: assert property (
    s_cycle_end |=> s_strobes_off ##0 (r_ff.st != EBR_ACC)
  ) else $error("ready low did not end the cycle");

  AST_READY_SYNC: assert property (
    $changed(r_ff.rdy_f) |-> $past(r_ff.rdy_sync[2]) == $past(r_ff.rdy_sync[1])
  ) else $error("ready taken before the synchroniser settled");

  AST_WAITSTATES_RUN: assert property (
    tick && (r_ff.st == EBR_ACC) && (r_ff.wcnt != '0) |=> (r_ff.st == EBR_ACC) && $changed(r_ff.wcnt)
  ) else $error("cycle left before its programmed waitstates");

  AST_STROBE_DELAY: assert property (
    tick && (r_ff.st == EBR_ADDR) |=> ($past(r_ff.cfg[CFG_RWDLY_BIT]) ? s_strobes_off : (RD_N != WR_N))
  ) else $error("strobe leading edge wrong for the delay option");

  AST_MUX_IDLE_WAIT: assert property (
    s_cycle_end ##0 r_ff.cfg[CFG_MUX_BIT] |=> (r_ff.st == EBR_MUXW) ##1 (r_ff.st == EBR_MUXW)
  ) else $error("multiplexed cycle without idle waitstate");

  // counted in CLOCK cycles, so only meaningful for the default divider
  AST_GAP_MUX_TRI: assert property (
    s_cycle_end ##0 r_ff.cfg[CFG_MUX_BIT] && r_ff.cfg[CFG_TRI_BIT] && r_ff.pend && r_ff.hld_f && (CLOCK_OUTPUT_PIN_HALF == 1)
      |=> (r_ff.st != EBR_ADDR) [*4] ##1 (ALE || !$past(r_ff.hld_f))
  ) else $error("gap after multiplexed cycle with tristate wait is wrong");

  AST_GAP_DEMUX: assert property (
    s_cycle_end ##0 !r_ff.cfg[CFG_MUX_BIT] && !r_ff.cfg[CFG_TRI_BIT] && r_ff.pend && r_ff.hld_f |=> ALE && !CS_N
  ) else $error("demultiplexed cycle left a gap");

  AST_GRANT_AFTER_CYCLE: assert property (
    $rose(r_ff.st == EBR_REL) |-> $past(r_ff.st) == EBR_IDLE
  ) else $error("bus released during a cycle");

  AST_RELEASE_FLOATS: assert property (
    !HOLD_GRANT_N |-> !CS_N_OE && !BUS_OE && CS_N
  ) else $error("bus driven while granted away");

  AST_HOLD_KEEPS_BUS: assert property (
    tick && (r_ff.st == EBR_HELD) && !r_ff.hld_f |=> (r_ff.st == EBR_HELD) && !HOLD_GRANT_N
  ) else $error("bus regained while hold still active");

  AST_REGAIN_RUNS: assert property (
    tick && (r_ff.st == EBR_HELD) && r_ff.hld_f |=> HOLD_GRANT_N && BUS_REQUEST_OUT_N && !BUS_OE
  ) else $error("regain sequence not started on hold release");

  AST_DRIVE_AFTER_GRANT: assert property (
    $rose(BUS_OE) |-> HOLD_GRANT_N && $past(HOLD_GRANT_N) && (r_ff.st == EBR_IDLE)
  ) else $error("bus driven before grant removed");

  AST_GRANT_ON_CLOCK_OUTPUT_PIN: assert property (
    $changed(HOLD_GRANT_N) || $changed(BUS_REQUEST_OUT_N) |-> $rose(CLOCK_OUTPUT_PIN)
  ) else $error("grant or request changed off a clock-output edge");

  AST_PINS_ON_TICK: assert property (
    !tick |=> $stable(r_ff.pins)
  ) else $error("bus pins changed off a clock-output edge");

  AST_HOLD_SYNC: assert property (
    $changed(r_ff.hld_f) |-> $past(r_ff.hld_sync[2]) == $past(r_ff.hld_sync[1])
  ) else $error("hold taken before the synchroniser settled");

  AST_GRANT_AFTER_RELEASE: assert property (
    $fell(HOLD_GRANT_N) |-> !$past(BUS_OE) && !$past(CS_N_OE)
  ) else $error("grant given before the bus was released");

endmodule // ebr_arbiter
`default_nettype wire

/* sim/ebr_responder.sv */
/*
  Far-side model: a memory responder that answers with ready, and an alternate
  master that asks for the bus through hold.
  Assumes the chip select pin is already resolved against its pullup.
*/
`default_nettype none
module ebr_responder
  import ebr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CS_PIN,
  input wire logic [7:0] DELAY,
  input wire logic HOLD_REQ,
  output logic READY_N,
  output logic HOLD_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff <= 8'h00;
      READY_N <= 1'b1;
      HOLD_N <= 1'b1;
    end else begin
      // hold may drop whether or not the bus was asked back
      HOLD_N <= ~HOLD_REQ;
      if (CS_PIN) begin
        // withdrawn only after the command ends, so capture stays safe
        cnt_ff <= 8'h00;
        READY_N <= 1'b1;
      end else if (cnt_ff >= DELAY) begin
        READY_N <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule // ebr_responder
`default_nettype wire

/* sim/ebr_arbiter_bench.sv */
/*
  Self-checking bench for ebr_arbiter: bus cycle lengths, ready, strobe delay,
  post-cycle gaps and hold arbitration, driven over APB.
  Assumes ebr_pkg and the ebr_responder far-side model.
*/
`default_nettype none
module ebr_arbiter_bench
  import ebr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, hold_req = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, rq;
  logic [7:0] rdy_dly = 8'h00;
  logic PREADY, PSLVERR, READY_N, HOLD_N, CLOCK_OUTPUT_PIN, ALE, RD_N, WR_N, BUS_OE, CS_N, CS_N_OE;
  logic HOLD_GRANT_N, BUS_REQUEST_OUT_N, rerr;
  int n_fail = 0, cmp_count = 0, c, L;

  ebr_arbiter #(.CLOCK_OUTPUT_PIN_HALF(1)) i_dut (.CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .READY_N, .HOLD_N, .CLOCK_OUTPUT_PIN, .ALE, .RD_N, .WR_N, .BUS_OE,
    .CS_N, .CS_N_OE, .HOLD_GRANT_N, .BUS_REQUEST_OUT_N);
  ebr_responder i_resp (.CLOCK, .RST_N, .CS_PIN(CS_N_OE ? CS_N : 1'b1), .DELAY(rdy_dly),
    .HOLD_REQ(hold_req), .READY_N, .HOLD_N);

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    n_fail++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail(m);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rq = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(negedge CLOCK);
  endtask
  task automatic cfg(input logic [3:0] w, input logic dl, mx, tr, rd, wn);
    apb(1'b1, CFG_OFFSET, {23'h0, wn, rd, tr, mx, dl, w});
  endtask
  task automatic start(input logic wr);
    apb(1'b1, CMD_OFFSET, {30'h0, wr, 1'b1});
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return RD_N & WR_N;
      1: return ALE;
      2: return BUS_OE;
      3: return HOLD_GRANT_N;
      default: return BUS_REQUEST_OUT_N;
    endcase
  endfunction
  // counts negedges until the chosen pin reaches lvl
  task automatic wait_for(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) !== lvl && n < 500) begin
      @(negedge CLOCK);
      n++;
    end
    if (n >= 500) begin
      fail("wait timed out");
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rq, CFG_RESET, "cfg reset value");
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk({28'h0, rq[3:0]}, {28'h0, EBR_IDLE}, "idle state");
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
  endtask
  task automatic t_length();
    logic [3:0] w;
    for (int k = 0; k < 3; k++) begin
      w = (k == 1) ? 4'hf : 4'(k * 3);
      cfg(w, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      start(k[0]);
      wait_for(0, 1'b0, c);
      wait_for(0, 1'b1, L);
      chk(32'(L), 32'(2 * (w + 1)), "strobe length");
    end
  endtask
  task automatic t_ready();
    logic [15:0] n0;
    rdy_dly <= 8'h1e;
    cfg(4'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    n0 = rq[31:16];
    start(1'b0);
    wait_for(0, 1'b0, c);
    wait_for(0, 1'b1, L);
    chk({31'h0, READY_N}, 32'h0, "ended without ready");
    apb(1'b0, STATUS_OFFSET, 32'h0);
    n0 = rq[31:16] - n0;
    chk({31'h0, n0 != 16'h0}, 32'h1, "no ready waitstates");
    chk(32'(L), 32'(2 * (2 + n0)), "strobe with ready waits");
    rdy_dly <= 8'h00;
  endtask
  task automatic t_dly();
    for (int d = 0; d < 2; d++) begin
      cfg(4'h0, d[0], 1'b0, 1'b0, 1'b0, 1'b0);
      start(1'b1);
      wait_for(1, 1'b1, c);
      chk({31'h0, CS_N}, 32'h0, "chip select not active");
      wait_for(0, 1'b0, L);
      chk(32'(L), 32'(2 + 2 * d), "strobe lead");
      wait_for(0, 1'b1, c);
    end
  endtask
  task automatic t_gap();
    for (int k = 0; k < 4; k++) begin
      cfg(4'h2, 1'b0, k[0], k[1], 1'b0, 1'b0);
      start(1'b0);
      wait_for(0, 1'b0, c);
      start(1'b1);
      wait_for(0, 1'b1, c);
      wait_for(1, 1'b1, L);
      chk(32'(L), 32'(2 * (k[0] + k[1])), "gap to next cycle");
      wait_for(0, 1'b0, c);
      wait_for(0, 1'b1, c);
    end
  endtask
  task automatic t_hold(input logic want);
    cfg(4'h7, 1'b0, 1'b0, 1'b0, 1'b0, want);
    start(1'b0);
    wait_for(0, 1'b0, c);
    hold_req <= 1'b1;
    wait_for(2, 1'b0, c);
    chk({31'h0, RD_N & WR_N}, 32'h1, "released mid cycle");
    chk({29'h0, CS_N, CS_N_OE, HOLD_GRANT_N}, 32'h5, "release state");
    wait_for(3, 1'b0, c);
    chk({30'h0, BUS_OE, CLOCK_OUTPUT_PIN}, 32'h1, "grant off tick");
    if (want) begin
      start(1'b0);
    end
    wait_for(4, ~want, c);
    repeat (20) @(negedge CLOCK);
    chk({29'h0, HOLD_GRANT_N, BUS_OE, BUS_REQUEST_OUT_N}, {31'h0, ~want}, "held state");
    hold_req <= 1'b0;
    wait_for(3, 1'b1, c);
    chk({30'h0, BUS_OE, BUS_REQUEST_OUT_N}, 32'h1, "regain order");
    wait_for(2, 1'b1, c);
    chk({31'h0, CS_N_OE}, 32'h1, "cs not driven");
    if (want) begin
      wait_for(0, 1'b0, c);
      wait_for(0, 1'b1, c);
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(negedge CLOCK);
    t_regs();
    t_length();
    t_ready();
    t_dly();
    t_gap();
    t_hold(1'b0);
    t_hold(1'b1);
    give_verdict();
  end
  // whole run needs a few hundred cycles
  initial begin
    #200_000;
    fail("watchdog expired");
    give_verdict();
  end
endmodule // ebr_arbiter_bench
`default_nettype wire
